// file: rsu_pkg.sv
package rsu_pkg;
  // ---------------------------------------------------------------
  // Clock and link timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 25000000;
  localparam int unsigned BAUD_MIN     = 300;
  localparam int unsigned BAUD_MAX     = 250000;
  localparam int unsigned BAUD_DEFAULT = 115200;
  // Sixteen samples per bit time
  localparam int unsigned OVERSAMPLE   = 16;
  localparam int unsigned OS_MID       = 8;
  // Divider for sixteen ticks per bit at the default rate
  localparam int unsigned DIV_DEFAULT  =
    CLK_HZ / (BAUD_DEFAULT * OVERSAMPLE);
  localparam int unsigned DIV_W        = 16;
  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int unsigned DATA_BITS    = 8;
  localparam logic        START_LEVEL  = 1'b0;
  localparam logic        STOP_LEVEL   = 1'b1;
  localparam logic        IDLE_LEVEL   = 1'b1;
  localparam int unsigned FIFO_DEPTH   = 8;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  BYTE_RESET   = 8'h00;
  localparam logic [3:0]  CNT_RESET    = 4'h0;
endpackage

// file: rsu_link_if.sv
`timescale 1ns/10ps
// Four-wire link: serial lines in each direction, turnaround and reset
interface rsu_link_if;
  logic dev_txd;   // Serial data from the module
  logic host_txd;  // Serial data from the far node
  logic turn;      // Direction request from the far node
  logic reset_n;   // Module reset from the far node, active low
  modport dev  (output dev_txd, input host_txd, input turn, input reset_n);
  modport host (input dev_txd, output host_txd, output turn,
                output reset_n);
endinterface

// file: rsu_fifo.sv
`timescale 1ns/10ps
// Synchronous FIFO with valid/ready on both sides
module rsu_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  full_o,
  output logic                  empty_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  // Flags and handshakes
  assign full_o      = (cnt_reg == DEPTH[AW:0]);
  assign empty_o     = (cnt_reg == '0);
  assign in_ready_o  = !full_o;
  assign out_valid_o = !empty_o;
  assign out_data_o  = mem_reg[rd_reg];
  assign push        = in_valid_i && !full_o;
  assign pop         = out_ready_i && !empty_o;

  // Pointer and count update
  always_comb begin
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end
endmodule

// file: rsu_dev.sv
`timescale 1ns/10ps
// Contract
// - Eight data bits, no parity, one stop
// - Start bit zero, stop bit one
// - Least significant bit sent first
// - Rate programmable 300 to 250K, matched
// - Independent concurrent transmit and receive paths
// - Buffered mode captures received bytes automatically
// - Host drives turnaround when module is slave
// - Turnaround is input only, never driven
// - Slaves are turned around by the host, never by themselves
// - Low reset input resets the module
module rsu_dev
  import rsu_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  rsu_link_if.dev               link,
  input  wire logic [DIV_W-1:0] div_i,
  input  wire logic             slave_mode_i,
  input  wire logic             buffered_i,
  input  wire logic             tx_valid_i,
  output logic                  tx_ready_o,
  input  wire logic [7:0]       tx_data_i,
  output logic                  rx_valid_o,
  input  wire logic             rx_ready_i,
  output logic      [7:0]       rx_data_o,
  output logic                  rx_overrun_o,
  output logic                  rx_frame_err_o,
  output logic                  tx_allowed_o,
  output logic                  reset_out_n_o
);
  // ---------------------------------------------------------------
  // Reset from the link pin combined with local reset
  // ---------------------------------------------------------------
  logic rst_n;
  assign rst_n = reset_n_i & link.reset_n;
  assign reset_out_n_o = rst_n;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] rxd_sync_reg, turn_sync_reg;
  logic       rxd_reg, turn_reg;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rxd_sync_reg  <= 3'h7;
      turn_sync_reg <= 3'h0;
      rxd_reg       <= IDLE_LEVEL;
      turn_reg      <= 1'b0;
    end else begin
      rxd_sync_reg  <= {rxd_sync_reg[1:0], link.host_txd};
      turn_sync_reg <= {turn_sync_reg[1:0], link.turn};
      if (rxd_sync_reg[2] == rxd_sync_reg[1]) begin
        rxd_reg <= rxd_sync_reg[2];
      end
      if (turn_sync_reg[2] == turn_sync_reg[1]) begin
        turn_reg <= turn_sync_reg[2];
      end
    end
  end

  // Slave starts a frame only while host grants the line; master always may
  assign tx_allowed_o = !slave_mode_i || turn_reg;

  // ---------------------------------------------------------------
  // Sample tick divider, sixteen ticks per bit
  // ---------------------------------------------------------------
  logic [DIV_W-1:0] div_reg, div_next;
  logic             tick;
  assign tick = (div_reg == '0);
  always_comb begin
    div_next = tick ? div_i : div_reg - 1'b1;
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    RSU_TX_IDLE  = 4'b0001,
    RSU_TX_START = 4'b0010,
    RSU_TX_DATA  = 4'b0100,
    RSU_TX_STOP  = 4'b1000
  } rsu_tx_state_t;
  rsu_tx_state_t tx_st_reg, tx_st_next;
  logic [7:0] tx_sh_reg, tx_sh_next;
  logic [3:0] tx_os_reg, tx_os_next, tx_bit_reg, tx_bit_next;
  logic       txd_reg, txd_next;
  logic       tx_end;
  assign tx_ready_o = (tx_st_reg == RSU_TX_IDLE) && tx_allowed_o;
  assign tx_end     = tick && (tx_os_reg == 4'(OVERSAMPLE - 1));
  assign link.dev_txd = txd_reg;

  // Next transmit state
  always_comb begin
    tx_st_next  = tx_st_reg;
    tx_sh_next  = tx_sh_reg;
    tx_os_next  = tick ? tx_os_reg + 1'b1 : tx_os_reg;
    tx_bit_next = tx_bit_reg;
    txd_next    = txd_reg;
    case (tx_st_reg)
      RSU_TX_IDLE: begin
        txd_next   = IDLE_LEVEL;
        tx_os_next = CNT_RESET;
        if (tx_valid_i && tx_allowed_o) begin
          tx_sh_next = tx_data_i;
          txd_next   = START_LEVEL;
          tx_st_next = RSU_TX_START;
        end
      end
      RSU_TX_START: begin
        if (tx_end) begin
          txd_next    = tx_sh_reg[0];
          tx_sh_next  = {1'b0, tx_sh_reg[7:1]};
          tx_bit_next = CNT_RESET;
          tx_st_next  = RSU_TX_DATA;
        end
      end
      RSU_TX_DATA: begin
        if (tx_end) begin
          if (tx_bit_reg == 4'(DATA_BITS - 1)) begin
            txd_next   = STOP_LEVEL;
            tx_st_next = RSU_TX_STOP;
          end else begin
            txd_next    = tx_sh_reg[0];
            tx_sh_next  = {1'b0, tx_sh_reg[7:1]};
            tx_bit_next = tx_bit_reg + 1'b1;
          end
        end
      end
      RSU_TX_STOP: begin
        if (tx_end) begin
          tx_st_next = RSU_TX_IDLE;
        end
      end
      default: tx_st_next = RSU_TX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_reg  <= RSU_TX_IDLE;
      tx_sh_reg  <= BYTE_RESET;
      tx_os_reg  <= CNT_RESET;
      tx_bit_reg <= CNT_RESET;
      txd_reg    <= IDLE_LEVEL;
    end else begin
      tx_st_reg  <= tx_st_next;
      tx_sh_reg  <= tx_sh_next;
      tx_os_reg  <= tx_os_next;
      tx_bit_reg <= tx_bit_next;
      txd_reg    <= txd_next;
    end
  end

  // ---------------------------------------------------------------
  // Receiver, runs independently of the transmitter
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    RSU_RX_IDLE  = 4'b0001,
    RSU_RX_START = 4'b0010,
    RSU_RX_DATA  = 4'b0100,
    RSU_RX_STOP  = 4'b1000
  } rsu_rx_state_t;
  rsu_rx_state_t rx_st_reg, rx_st_next;
  logic [7:0] rx_sh_reg, rx_sh_next;
  logic [3:0] rx_os_reg, rx_os_next, rx_bit_reg, rx_bit_next;
  logic       rx_done, rx_ok, rx_err_next, rx_err_reg;
  logic       ff_ready, ff_empty;

  // Next receive state
  always_comb begin
    rx_st_next  = rx_st_reg;
    rx_sh_next  = rx_sh_reg;
    rx_os_next  = tick ? rx_os_reg + 1'b1 : rx_os_reg;
    rx_bit_next = rx_bit_reg;
    rx_done     = 1'b0;
    rx_ok       = 1'b0;
    rx_err_next = 1'b0;
    case (rx_st_reg)
      RSU_RX_IDLE: begin
        rx_os_next = CNT_RESET;
        if (rxd_reg == START_LEVEL) begin
          rx_st_next = RSU_RX_START;
        end
      end
      RSU_RX_START: begin
        if (tick && rx_os_reg == 4'(OS_MID - 1)) begin
          rx_os_next = CNT_RESET;
          rx_bit_next = CNT_RESET;
          rx_st_next = (rxd_reg == START_LEVEL) ? RSU_RX_DATA
                                                : RSU_RX_IDLE;
        end
      end
      RSU_RX_DATA: begin
        if (tick && rx_os_reg == 4'(OVERSAMPLE - 1)) begin
          rx_sh_next = {rxd_reg, rx_sh_reg[7:1]};
          rx_bit_next = rx_bit_reg + 1'b1;
          if (rx_bit_reg == 4'(DATA_BITS - 1)) begin
            rx_st_next = RSU_RX_STOP;
          end
        end
      end
      RSU_RX_STOP: begin
        if (tick && rx_os_reg == 4'(OVERSAMPLE - 1)) begin
          rx_done     = 1'b1;
          rx_ok       = (rxd_reg == STOP_LEVEL);
          rx_err_next = !rx_ok;
          rx_st_next  = RSU_RX_IDLE;
        end
      end
      default: rx_st_next = RSU_RX_IDLE;
    endcase
  end

  // Overrun when a good byte finds the buffer full
  logic ovr_reg, ovr_next;
  assign ovr_next = rx_done && rx_ok && !ff_ready;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_reg  <= RSU_RX_IDLE;
      rx_sh_reg  <= BYTE_RESET;
      rx_os_reg  <= CNT_RESET;
      rx_bit_reg <= CNT_RESET;
      rx_err_reg <= 1'b0;
      ovr_reg    <= 1'b0;
    end else begin
      rx_st_reg  <= rx_st_next;
      rx_sh_reg  <= rx_sh_next;
      rx_os_reg  <= rx_os_next;
      rx_bit_reg <= rx_bit_next;
      rx_err_reg <= rx_err_next;
      ovr_reg    <= ovr_next;
    end
  end
  assign rx_frame_err_o = rx_err_reg;
  assign rx_overrun_o   = ovr_reg;

  // ---------------------------------------------------------------
  // Receive buffer; depth one behaviour in single-byte mode
  // ---------------------------------------------------------------
  logic push_ok;
  assign push_ok = buffered_i ? 1'b1 : ff_empty;
  logic ff_in_ready;
  assign ff_ready = ff_in_ready && push_ok;
  rsu_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .clk_i       (clk_i),
    .reset_n_i   (rst_n),
    .in_valid_i  (rx_done && rx_ok && push_ok),
    .in_ready_o  (ff_in_ready),
    .in_data_i   (rx_sh_reg),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  (rx_data_o),
    .full_o      (),
    .empty_o     (ff_empty)
  );
endmodule

// file: rsu_host.sv
`timescale 1ns/10ps
// Far node: bit-timed transmitter and receiver, drives turn and reset
module rsu_host
  import rsu_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  rsu_link_if.host              link,
  input  wire logic [DIV_W-1:0] div_i,
  input  wire logic             grant_turn_i,
  input  wire logic             dev_reset_n_i,
  input  wire logic             tx_valid_i,
  output logic                  tx_ready_o,
  input  wire logic [7:0]       tx_data_i,
  output logic                  rx_valid_o,
  output logic      [7:0]       rx_data_o
);
  // ---------------------------------------------------------------
  // Pin drives and receive sync
  // ---------------------------------------------------------------
  logic [2:0] rxd_sync_reg;
  logic       rxd_reg, turn_reg, rst_reg;
  assign link.turn    = turn_reg;
  assign link.reset_n = rst_reg;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rxd_sync_reg <= 3'h7;
      rxd_reg      <= IDLE_LEVEL;
      turn_reg     <= 1'b0;
      rst_reg      <= 1'b0;
    end else begin
      rxd_sync_reg <= {rxd_sync_reg[1:0], link.dev_txd};
      if (rxd_sync_reg[2] == rxd_sync_reg[1]) begin
        rxd_reg <= rxd_sync_reg[2];
      end
      turn_reg <= grant_turn_i;
      rst_reg  <= dev_reset_n_i;
    end
  end

  // ---------------------------------------------------------------
  // Tick divider, same rate as the module
  // ---------------------------------------------------------------
  logic [DIV_W-1:0] div_reg;
  logic             tick;
  assign tick = (div_reg == '0);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_reg <= '0;
    end else begin
      div_reg <= tick ? div_i : div_reg - 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Transmitter: 10-bit frame shifter
  // ---------------------------------------------------------------
  logic [9:0] tx_fr_reg;
  logic [3:0] tx_os_reg, tx_n_reg;
  assign tx_ready_o    = (tx_n_reg == 4'h0);
  assign link.host_txd = tx_fr_reg[0];
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_fr_reg <= 10'h3ff;
      tx_os_reg <= CNT_RESET;
      tx_n_reg  <= CNT_RESET;
    end else if (tx_n_reg == 4'h0) begin
      tx_os_reg <= CNT_RESET;
      if (tx_valid_i) begin
        // Stop, data LSB first, start
        tx_fr_reg <= {STOP_LEVEL, tx_data_i, START_LEVEL};
        tx_n_reg  <= 4'ha;
      end
    end else if (tick) begin
      tx_os_reg <= tx_os_reg + 1'b1;
      if (tx_os_reg == 4'(OVERSAMPLE - 1)) begin
        tx_fr_reg <= {IDLE_LEVEL, tx_fr_reg[9:1]};
        tx_n_reg  <= tx_n_reg - 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Receiver: centre sampled, stop checked
  // ---------------------------------------------------------------
  logic       rx_busy_reg;
  logic [3:0] rx_os_reg, rx_n_reg;
  logic [8:0] rx_sh_reg;
  logic       rxv_reg;
  logic [7:0] rxd_out_reg;
  assign rx_valid_o = rxv_reg;
  assign rx_data_o  = rxd_out_reg;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_busy_reg <= 1'b0;
      rx_os_reg   <= CNT_RESET;
      rx_n_reg    <= CNT_RESET;
      rx_sh_reg   <= 9'h000;
      rxv_reg     <= 1'b0;
      rxd_out_reg <= BYTE_RESET;
    end else begin
      rxv_reg <= 1'b0;
      if (!rx_busy_reg) begin
        rx_os_reg <= 4'(OS_MID);
        rx_n_reg  <= CNT_RESET;
        if (rxd_reg == START_LEVEL) begin
          rx_busy_reg <= 1'b1;
        end
      end else if (tick) begin
        rx_os_reg <= rx_os_reg + 1'b1;
        if (rx_os_reg == 4'(OVERSAMPLE - 1)) begin
          rx_sh_reg <= {rxd_reg, rx_sh_reg[8:1]};
          rx_n_reg  <= rx_n_reg + 1'b1;
          if (rx_n_reg == 4'h0 && rxd_reg != START_LEVEL) begin
            rx_busy_reg <= 1'b0;
          end
          if (rx_n_reg == 4'(DATA_BITS + 1)) begin
            rx_busy_reg <= 1'b0;
            rxv_reg     <= (rxd_reg == STOP_LEVEL);
            rxd_out_reg <= rx_sh_reg[8:1];
          end
        end
      end
    end
  end
endmodule

// file: rsu_link_checker.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Framing checker on both serial lines of the link
// ----------------------------------------------------------------
module rsu_link_checker #(
  parameter int DIV = 2
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic dev_txd,
  input wire logic host_txd,
  input wire logic turn,
  input wire logic reset_n
);
  localparam int B   = 16 * (DIV + 1);
  localparam int T   = DIV + 1;
  localparam int SHI = B - T - 2;
  localparam int SLO = 9 * B + 1;
  localparam int END = 10 * B - T - 2;

  logic [1:0]       line;
  logic [1:0]       prev_reg;
  logic [1:0]       prev_next;
  logic [1:0][15:0] cnt_reg;
  logic [1:0][15:0] cnt_next;

  assign line = {host_txd, dev_txd};

  // Frame position per line, started by a falling edge
  always_comb begin
    prev_next = line;
    for (int i = 0; i < 2; i++) begin
      cnt_next[i] = cnt_reg[i] + 16'h0001;
      if (cnt_reg[i] == 16'h0000)
        cnt_next[i] = {15'h0000, prev_reg[i] & ~line[i]};
      else if (cnt_reg[i] >= 16'(END))
        cnt_next[i] = 16'h0000;
    end
  end

  // Counter registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_reg <= 2'h3;
      cnt_reg  <= '0;
    end else begin
      prev_reg <= prev_next;
      cnt_reg  <= cnt_next;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_dev_start;
    (cnt_reg[0] >= 1 && cnt_reg[0] <= SHI) |-> !dev_txd;
  endproperty
  a_dev_start: assert property (p_dev_start)
    else $error("module start bit not low");

  property p_dev_stop;
    (cnt_reg[0] >= SLO && cnt_reg[0] <= END) |-> dev_txd;
  endproperty
  a_dev_stop: assert property (p_dev_stop)
    else $error("module stop bit missing after eight bits");

  property p_dev_edges;
    (cnt_reg[0] != 0 && $changed(dev_txd))
      |-> (cnt_reg[0] % B == 0 || cnt_reg[0] % B >= B - T - 1);
  endproperty
  a_dev_edges: assert property (p_dev_edges)
    else $error("module line changed inside a bit cell");

  property p_host_start;
    (cnt_reg[1] >= 1 && cnt_reg[1] <= SHI) |-> !host_txd;
  endproperty
  a_host_start: assert property (p_host_start)
    else $error("far start bit not low");

  property p_host_stop;
    (cnt_reg[1] >= SLO && cnt_reg[1] <= END) |-> host_txd;
  endproperty
  a_host_stop: assert property (p_host_stop)
    else $error("far stop bit missing after eight bits");

  property p_host_edges;
    (cnt_reg[1] != 0 && $changed(host_txd))
      |-> (cnt_reg[1] % B == 0 || cnt_reg[1] % B >= B - T - 1);
  endproperty
  a_host_edges: assert property (p_host_edges)
    else $error("far line changed inside a bit cell");

  property p_reset_idle;
    !reset_n |=> dev_txd;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("module line not idle during reset");

  property p_idle_after;
    (cnt_reg[0] == END) |=> dev_txd;
  endproperty
  a_idle_after: assert property (p_idle_after)
    else $error("module line not idle after frame");

  // Main scenarios reached
  c_dev_frame: cover property (cnt_reg[0] == END);
  c_host_frame: cover property (cnt_reg[1] == END);
  c_link_reset: cover property ($fell(reset_n));
  c_turn_grant: cover property ($rose(turn));
endmodule

// file: tb.sv
`timescale 1ns/10ps
module tb
  import rsu_pkg::*;
;
  localparam int DIVV = 6;  // Seven clocks a tick, about 223K baud
  localparam int B    = 16 * (DIVV + 1);

  logic             clk, reset_n, slave_mode, buffered, grant, dev_rst_n;
  logic             d_tx_valid, d_tx_ready, d_rx_valid, d_rx_ready;
  logic             h_tx_valid, h_tx_ready, h_rx_valid, d_allowed;
  logic             d_overrun, d_frame_err, d_reset_out_n;
  logic [DIV_W-1:0] div;
  logic [7:0]       d_tx_data, h_tx_data, d_rx_data, h_rx_data, a, b;
  logic [7:0]       q_dev[$], q_host[$], q_wire[$];
  int               err_total, checked, ovr_seen, ovr_exp, seed;

  rsu_link_if link ();
  rsu_dev rsu_dev_i (.clk_i(clk), .reset_n_i(reset_n), .link(link),
    .div_i(div), .slave_mode_i(slave_mode), .buffered_i(buffered),
    .tx_valid_i(d_tx_valid), .tx_ready_o(d_tx_ready),
    .tx_data_i(d_tx_data), .rx_valid_o(d_rx_valid),
    .rx_ready_i(d_rx_ready), .rx_data_o(d_rx_data),
    .rx_overrun_o(d_overrun), .rx_frame_err_o(d_frame_err),
    .tx_allowed_o(d_allowed), .reset_out_n_o(d_reset_out_n));
  rsu_host rsu_host_i (.clk_i(clk), .reset_n_i(reset_n), .link(link),
    .div_i(div), .grant_turn_i(grant), .dev_reset_n_i(dev_rst_n),
    .tx_valid_i(h_tx_valid), .tx_ready_o(h_tx_ready),
    .tx_data_i(h_tx_data), .rx_valid_o(h_rx_valid),
    .rx_data_o(h_rx_data));
  rsu_link_checker #(.DIV(DIVV)) rsu_link_checker_i (.clk_i(clk),
    .reset_n_i(reset_n), .dev_txd(link.dev_txd),
    .host_txd(link.host_txd), .turn(link.turn), .reset_n(link.reset_n));

  // Clock
  always #20 clk = ~clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (err_total == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One byte from either end, held until taken
  task automatic send(input bit from_dev, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    if (from_dev) {d_tx_valid, d_tx_data} = {1'b1, d};
    else {h_tx_valid, h_tx_data} = {1'b1, d};
    while ((from_dev ? d_tx_ready : h_tx_ready) !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 4000) begin
        err_total++;
        complete_run();
      end
    end
    @(negedge clk);
    if (from_dev) {d_tx_valid, d_tx_data} = {1'b0, ~d};
    else {h_tx_valid, h_tx_data} = {1'b0, ~d};
  endtask

  // Bounded wait for overruns or for all expected bytes
  task automatic settle(input bit ovr);
    int n;
    n = 0;
    while (ovr ? ovr_seen < ovr_exp
               : q_dev.size() + q_host.size() + q_wire.size() != 0) begin
      @(negedge clk);
      n++;
      if (n > 9000) begin
        err_total++;
        complete_run();
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------
  // Received bytes against the oldest expectation
  always @(posedge clk) begin
    if (d_rx_valid === 1'b1 && d_rx_ready === 1'b1)
      check(d_rx_data,
            q_dev.size() ? q_dev.pop_front() : 8'hxx);
    if (h_rx_valid === 1'b1)
      check(h_rx_data,
            q_host.size() ? q_host.pop_front() : 8'hxx);
    if (d_overrun === 1'b1)
      ovr_seen++;
    if (d_frame_err === 1'b1)
      check(8'h01, 8'h00);
  end

  // Decode frames on the module's line at bit centres
  initial begin
    logic [7:0] w;
    logic       s0;
    forever begin
      @(posedge clk);
      if (reset_n === 1'b1 && link.dev_txd === 1'b0) begin
        repeat (B / 2 - 2) @(posedge clk);
        s0 = link.dev_txd;
        for (int i = 0; i < 8; i++) begin
          repeat (B) @(posedge clk);
          w[i] = link.dev_txd;
        end
        repeat (B) @(posedge clk);
        check({7'h00, s0}, {7'h00, START_LEVEL});
        check({7'h00, link.dev_txd}, {7'h00, STOP_LEVEL});
        check(w, q_wire.size() ? q_wire.pop_front() : 8'hxx);
      end
    end
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {clk, reset_n, slave_mode, d_tx_valid, h_tx_valid} = 5'h00;
    {buffered, d_rx_ready, grant, dev_rst_n} = 4'hf;
    {d_tx_data, h_tx_data} = 16'h0000;
    div = DIV_W'(DIVV);
    {err_total, checked, ovr_seen, ovr_exp} = 128'h0;
    seed = 48908;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    check({7'h00, link.dev_txd}, {7'h00, IDLE_LEVEL});
    check({7'h00, link.host_txd}, {7'h00, IDLE_LEVEL});
    // Both directions at once
    for (int i = 0; i < 4; i++) begin
      a = 8'($random(seed));
      b = 8'($random(seed));
      q_host.push_back(a);
      q_wire.push_back(a);
      q_dev.push_back(b);
      fork
        send(1'b1, a);
        send(1'b0, b);
      join
    end
    settle(1'b0);
    // Buffered then single byte mode, stalled until one is dropped
    for (int m = 0; m < 2; m++) begin
      @(negedge clk);
      buffered = (m == 0);
      d_rx_ready = 1'b0;
      ovr_exp++;
      for (int i = 0; i <= (m ? 1 : FIFO_DEPTH); i++) begin
        b = 8'($random(seed));
        if (i < (m ? 1 : FIFO_DEPTH)) q_dev.push_back(b);
        send(1'b0, b);
      end
      settle(1'b1);
      check(8'(ovr_seen), 8'(ovr_exp));
      check({7'h00, d_rx_valid}, 8'h01);
      @(negedge clk);
      d_rx_ready = 1'b1;
      settle(1'b0);
    end
    // Slave mode holds the byte until the turn grant
    @(negedge clk);
    {slave_mode, grant} = 2'h2;
    repeat (8) @(negedge clk);
    check({6'h00, d_tx_ready, d_allowed}, 8'h00);
    a = 8'($random(seed));
    q_host.push_back(a);
    q_wire.push_back(a);
    fork
      send(1'b1, a);
      begin
        repeat (40) @(negedge clk);
        check({7'h00, link.dev_txd}, 8'h01);
        grant = 1'b1;
      end
    join
    check({7'h00, d_allowed}, 8'h01);
    settle(1'b0);
    slave_mode = 1'b0;
    // Module reset from the far end, then traffic again
    dev_rst_n = 1'b0;
    repeat (3) @(negedge clk);
    check({6'h00, d_reset_out_n, d_rx_valid}, 8'h00);
    dev_rst_n = 1'b1;
    repeat (4) @(negedge clk);
    check({7'h00, d_reset_out_n}, 8'h01);
    b = 8'($random(seed));
    q_dev.push_back(b);
    send(1'b0, b);
    settle(1'b0);
    complete_run();
  end
endmodule
